// >>> core/pd_strap_map.svh
// constants for the strap, decode and status pin block
`ifndef PD_STRAP_MAP_SVH
`define PD_STRAP_MAP_SVH
`define CORE_CLK_HZ      10000000
`define INIT_TIME_US     200
`define INIT_CYCLES      ((`INIT_TIME_US * (`CORE_CLK_HZ / 1000000)))
`define ADDR_HIGH        8'h62
`define ADDR_LOW         8'h42
`define SEL_FAULT        2'h0
`define SEL_ID           2'h1
`define SEL_GPO          2'h2
`define ORIENTATION_OUTPUT_HIGH_CODE 2'h2
`define V5               6'h05
`define V9               6'h09
`define V12              6'h0C
`define V15              6'h0F
`define V20              6'h14
`define V28              6'h1C
`define VSET_B0          9'h00F
`define VSET_B1          9'h02D
`define VSET_B2          9'h055
`define VSET_B3          9'h097
`define VSET_OPEN        9'h12C
`define I_BASE           4'h5
`define I_OPEN           4'hD
`define ISET_B0          9'h00B
`define ISET_B1          9'h01F
`define ISET_B2          9'h032
`define ISET_B3          9'h048
`define ISET_B4          9'h064
`define ISET_B5          9'h089
`define ISET_B6          9'h0B8
`define ISET_OPEN        9'h12C
`endif

// >>> core/pd_strap_pkg.sv
// types shared by the strap and status pin block
package pd_strap_pkg;
  typedef enum logic [1:0] {ST_OFF, ST_INIT, ST_RUN} life_type;
  typedef logic [5:0] volt_type;   // whole volts
  typedef logic [3:0] amp_type;    // quarter amperes
  typedef logic [8:0] ohm_type;    // tenths of a kilohm, all ones = open
endpackage

// >>> core/pd_sink_strap_and_status_pins.sv
// strap decode, enable gating and status pin drive of a pd sink
// Behaviour
// - start init on aux rise, or bus rise alone
// - hold reset while both supplies below falling
// - disable pin high disables functions and gate drive
// - control enable bit low stops functions in i2c mode
// - mode strap picks i2c address or pin mode
// - charger strap low limits detection to basic
// - bus voltage reading updated from converter
// - pin mode turns i2c pins analog
// - decode voltage resistor, open per extended bit
// - voltage is min of decode and fuse
// - decode current resistor in nine steps
// - current is min of decode and fuse
// - fault output high on mismatch or fault
// - clear fault on init, reset, select change
// - id output low as source, else hi-z
// - general output follows written level bit
// - output2 hi-z in init, polarity invertible
// - flag interrupts and may cut gate
// - strap pins become push-pull after init
// - debug output low when accessory present
// - orientation high only when status is 10b
// - output1 follows its level bit
// - interrupt is active-low open drain
`timescale 1ns/1ps
`include "pd_strap_map.svh"
module pd_sink_strap_and_status_pins #(
  parameter int INIT_CYCLES = `INIT_CYCLES
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_link_clk,
  input  wire logic                  i_aux_above_rise,
  input  wire logic                  i_aux_above_fall,
  input  wire logic                  i_bus_above_rise,
  input  wire logic                  i_bus_above_fall,
  input  wire logic                  i_system_disable_n,
  input  wire logic                  i_ctrl_enable,
  input  wire logic                  i_mode_strap_high,
  input  wire logic                  i_mode_strap_low,
  input  wire logic                  i_charger_strap_low,
  input  wire logic                  i_debug_strap,
  input  wire pd_strap_pkg::ohm_type i_voltage_setting_pin,
  input  wire pd_strap_pkg::ohm_type i_current_setting_pin,
  input  wire logic                  i_extended_range_capability_bit,
  input  wire pd_strap_pkg::volt_type i_fused_profile_voltage,
  input  wire pd_strap_pkg::amp_type i_fused_profile_current,
  input  wire logic                  i_adc_valid,
  input  wire logic [11:0]           i_adc_data,
  input  wire logic [1:0]            i_output2_function_select,
  input  wire logic                  i_output_polarity_bit,
  input  wire logic                  i_output2_level_bit,
  input  wire logic                  i_output1_level_bit,
  input  wire logic                  i_no_profile_match,
  input  wire logic                  i_fault_state,
  input  wire logic                  i_software_reset_command,
  input  wire logic                  i_hard_reset,
  input  wire logic                  i_attached_source,
  input  wire logic                  i_debug_accessory,
  input  wire logic [1:0]            i_status_orientation_output,
  input  wire logic                  i_flag_input_pin,
  input  wire logic                  i_flag_mask,
  input  wire logic                  i_flag_cuts_gate_bit,
  input  wire logic                  i_gate_request,
  output logic                       o_core_reset_n,
  output logic                       o_in_init,
  output logic                       o_func_enable,
  output logic                       o_i2c_mode,
  output logic [7:0]                 o_i2c_address,
  output logic                       o_i2c_pins_analog,
  output logic                       o_high_voltage_dedicated_charger,
  output pd_strap_pkg::volt_type     o_requested_voltage,
  output pd_strap_pkg::amp_type      o_requested_current,
  output pd_strap_pkg::amp_type      o_decoded_current_setting,
  output logic [11:0]                o_bus_voltage_reading,
  output logic                       o_fault_output2_pin_o,
  output logic                       o_fault_output2_pin_oe,
  output logic                       o_charger_strap_output1_pin_o,
  output logic                       o_charger_strap_output1_pin_oe,
  output logic                       o_mode_strap_orientation_pin_o,
  output logic                       o_mode_strap_orientation_pin_oe,
  output logic                       o_debug_pin_o,
  output logic                       o_debug_pin_oe,
  output logic                       o_int_pin_o,
  output logic                       o_int_pin_oe,
  output logic                       o_gate_enable
);
  import pd_strap_pkg::*;

  // pin inputs, two flops each before any logic reads them
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] pin_raw;       // asynchronous levels
  logic [NSYNC-1:0] pin_s1_r;      // first stage, read by second only
  logic [NSYNC-1:0] pin_s2_r;      // usable synchronous levels
  assign pin_raw = {i_aux_above_rise, i_aux_above_fall, i_bus_above_rise,
                    i_bus_above_fall, i_system_disable_n, i_mode_strap_high,
                    i_mode_strap_low, i_charger_strap_low, i_debug_strap,
                    i_flag_input_pin};
  logic aux_rise, aux_fall, bus_rise, bus_fall, dis_pin;
  logic strap_hi, strap_lo, chg_lo, flag_s;
  assign {aux_rise, aux_fall, bus_rise, bus_fall, dis_pin,
          strap_hi, strap_lo, chg_lo} = pin_s2_r[NSYNC-1:2];
  assign flag_s = pin_s2_r[0];

  // plain double flop for every single-bit pin
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  // resistor codes move slowly, so a word-wide double flop is tolerated;
  // a code caught mid-change settles on the next cycle
  ohm_type vset_s1_r, vset_s2_r;   // voltage resistor code
  ohm_type iset_s1_r, iset_s2_r;   // current resistor code
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vset_s1_r <= '0;
      vset_s2_r <= '0;
      iset_s1_r <= '0;
      iset_s2_r <= '0;
    end else begin
      vset_s1_r <= i_voltage_setting_pin;
      vset_s2_r <= vset_s1_r;
      iset_s1_r <= i_current_setting_pin;
      iset_s2_r <= iset_s1_r;
    end
  end

  // supply conditions
  logic supplies_low;   // both rails below falling threshold
  logic power_good;     // start condition, aux has priority
  assign supplies_low = !aux_fall && !bus_fall;
  assign power_good   = aux_rise || (bus_rise && !aux_fall);

  // life cycle: off, initialising, running
  life_type  life_r;
  logic [15:0] init_cnt_r;        // cycles spent in init
  logic        init_done;
  assign init_done = (init_cnt_r == 16'(INIT_CYCLES - 1));

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      life_r <= ST_OFF;
    end else if (supplies_low) begin
      life_r <= ST_OFF;
    end else begin
      unique case (life_r)
        ST_OFF:  if (power_good) life_r <= ST_INIT;
        ST_INIT: if (init_done) life_r <= ST_RUN;
        ST_RUN:  life_r <= ST_RUN;
      endcase
    end
  end

  // init timer, restarts whenever init is entered
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      init_cnt_r <= '0;
    end else if (life_r != ST_INIT) begin
      init_cnt_r <= '0;
    end else if (!init_done) begin
      init_cnt_r <= init_cnt_r + 16'h0001;
    end
  end

  logic running;     // init finished, supplies good
  logic end_init;    // last cycle of init
  assign running  = (life_r == ST_RUN);
  assign end_init = (life_r == ST_INIT) && init_done && !supplies_low;

  // strap latch at the end of init, held until the next init ends or reset
  logic i2c_mode_r;      // mode strap not floating
  logic addr_hi_r;       // mode strap pulled up
  logic high_voltage_dedicated_charger_r;         // charger strap not pulled down
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      i2c_mode_r <= 1'b0;
      addr_hi_r  <= 1'b0;
      high_voltage_dedicated_charger_r    <= 1'b1;
    end else if (end_init) begin
      i2c_mode_r <= strap_hi || strap_lo;
      addr_hi_r  <= strap_hi;
      high_voltage_dedicated_charger_r    <= !chg_lo;
    end
  end

  // enable gating: pin first, then the control bit in i2c mode
  logic func_en;
  assign func_en = running && !dis_pin
                   && (!i2c_mode_r || i_ctrl_enable);

  // voltage resistor decode, boundaries midway between codes
  volt_type vdec;
  always_comb begin
    if (vset_s2_r < `VSET_B0) vdec = `V5;
    else if (vset_s2_r < `VSET_B1) vdec = `V9;
    else if (vset_s2_r < `VSET_B2) vdec = `V12;
    else if (vset_s2_r < `VSET_B3) vdec = `V15;
    else if (vset_s2_r < `VSET_OPEN) vdec = `V20;
    else if (i_extended_range_capability_bit) vdec = `V28;
    else vdec = `V20;
  end

  // current resistor decode, nine quarter-amp steps
  amp_type idec;
  always_comb begin
    if (iset_s2_r < `ISET_B0) idec = `I_BASE;
    else if (iset_s2_r < `ISET_B1) idec = `I_BASE + 4'h1;
    else if (iset_s2_r < `ISET_B2) idec = `I_BASE + 4'h2;
    else if (iset_s2_r < `ISET_B3) idec = `I_BASE + 4'h3;
    else if (iset_s2_r < `ISET_B4) idec = `I_BASE + 4'h4;
    else if (iset_s2_r < `ISET_B5) idec = `I_BASE + 4'h5;
    else if (iset_s2_r < `ISET_B6) idec = `I_BASE + 4'h6;
    else if (iset_s2_r < `ISET_OPEN) idec = `I_BASE + 4'h7;
    else idec = `I_OPEN;
  end

  // request: lower of pins and fuses, tracked live in pin mode only
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_requested_voltage       <= `V5;
      o_requested_current       <= `I_BASE;
      o_decoded_current_setting <= `I_BASE;
    end else if (end_init || (running && !i2c_mode_r)) begin
      o_requested_voltage <= (vdec < i_fused_profile_voltage) ? vdec
                             : i_fused_profile_voltage;
      o_requested_current <= (idec < i_fused_profile_current) ? idec
                             : i_fused_profile_current;
      o_decoded_current_setting <= idec;
    end
  end

  // bus voltage converter on the link clock; toggle carries each word
  logic        lk_tog_r;         // flips once per new sample
  logic [11:0] lk_data_r;        // held until next sample
  always_ff @(posedge i_link_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lk_tog_r  <= 1'b0;
      lk_data_r <= '0;
    end else if (i_adc_valid) begin
      lk_tog_r  <= !lk_tog_r;
      lk_data_r <= i_adc_data;
    end
  end

  // toggle synchroniser and edge detect in the core domain
  // limitation: samples closer than four core cycles may be skipped
  logic tog_s1_r, tog_s2_r, tog_s3_r;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
    end else begin
      tog_s1_r <= lk_tog_r;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
    end
  end

  // reading register, readable at any time
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bus_voltage_reading <= '0;
    end else if (tog_s2_r != tog_s3_r) begin
      o_bus_voltage_reading <= lk_data_r;
    end
  end

  // fault indication, set beats clear in the same cycle
  logic [1:0] sel_d_r;           // previous select, for change detect
  logic       fault_r;
  logic       fault_clr;
  assign fault_clr = end_init || i_software_reset_command || i_hard_reset
                     || (sel_d_r != i_output2_function_select);
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_d_r <= `SEL_FAULT;
      fault_r <= 1'b0;
    end else begin
      sel_d_r <= i_output2_function_select;
      if (running && (i_no_profile_match || i_fault_state)) begin
        fault_r <= 1'b1;
      end else if (fault_clr) begin
        fault_r <= 1'b0;
      end
    end
  end

  // output2 function mux; polarity flips driven levels only
  logic o2_lvl, o2_oe;
  always_comb begin
    o2_lvl = 1'b0;
    o2_oe  = 1'b0;
    unique case (i_output2_function_select)
      `SEL_FAULT: begin
        o2_lvl = fault_r;
        o2_oe  = 1'b1;
      end
      `SEL_ID: begin
        o2_lvl = 1'b0;
        o2_oe  = i_attached_source;
      end
      `SEL_GPO: begin
        o2_lvl = i_output2_level_bit;
        o2_oe  = 1'b1;
      end
      default: begin
        o2_lvl = 1'b0;
        o2_oe  = 1'b0;
      end
    endcase
  end

  // pin drivers: all straps stay inputs until init completes
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_fault_output2_pin_o           <= 1'b0;
      o_fault_output2_pin_oe          <= 1'b0;
      o_charger_strap_output1_pin_o   <= 1'b0;
      o_charger_strap_output1_pin_oe  <= 1'b0;
      o_mode_strap_orientation_pin_o  <= 1'b0;
      o_mode_strap_orientation_pin_oe <= 1'b0;
      o_debug_pin_o                   <= 1'b1;
      o_debug_pin_oe                  <= 1'b0;
    end else begin
      o_fault_output2_pin_o  <= o2_lvl ^ i_output_polarity_bit;
      o_fault_output2_pin_oe <= running && o2_oe;
      o_charger_strap_output1_pin_o  <= i_output1_level_bit;
      o_charger_strap_output1_pin_oe <= running;
      o_mode_strap_orientation_pin_o <=
        (i_status_orientation_output == `ORIENTATION_OUTPUT_HIGH_CODE);
      o_mode_strap_orientation_pin_oe <= running;
      o_debug_pin_o  <= !i_debug_accessory;
      o_debug_pin_oe <= running;
    end
  end

  // flag input: interrupt and fast gate cut
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_int_pin_o   <= 1'b0;
      o_int_pin_oe  <= 1'b0;
      o_gate_enable <= 1'b0;
    end else begin
      o_int_pin_o   <= 1'b0;
      o_int_pin_oe  <= running && flag_s && !i_flag_mask;
      o_gate_enable <= func_en && i_gate_request
                       && !(flag_s && i_flag_cuts_gate_bit);
    end
  end

  // status and mode outputs
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_core_reset_n    <= 1'b0;
      o_in_init         <= 1'b0;
      o_func_enable     <= 1'b0;
      o_i2c_mode        <= 1'b0;
      o_i2c_address     <= `ADDR_LOW;
      o_i2c_pins_analog <= 1'b0;
      o_high_voltage_dedicated_charger <= 1'b1;
    end else begin
      o_core_reset_n    <= (life_r != ST_OFF) && !supplies_low;
      o_in_init         <= (life_r == ST_INIT);
      o_func_enable     <= func_en;
      o_i2c_mode        <= i2c_mode_r;
      o_i2c_address     <= addr_hi_r ? `ADDR_HIGH : `ADDR_LOW;
      o_i2c_pins_analog <= running && !i2c_mode_r;
      o_high_voltage_dedicated_charger <= high_voltage_dedicated_charger_r;
    end
  end

endmodule

// >>> verif/pd_pins_checker.sv
// concurrent checks on the strap and status pin block ports
`timescale 1ns/1ps
`include "pd_strap_map.svh"
module pd_pins_checker #(
  parameter int INIT_CYCLES = 20
) (
  input wire logic       i_core_clk,
  input wire logic       i_reset_n,
  input wire logic       i_aux_above_fall,
  input wire logic       i_bus_above_fall,
  input wire logic       i_system_disable_n,
  input wire logic [1:0] i_status_orientation_output,
  input wire logic       i_debug_accessory,
  input wire logic       i_output1_level_bit,
  input wire logic [1:0] i_output2_function_select,
  input wire logic       i_output2_level_bit,
  input wire logic       i_output_polarity_bit,
  input wire logic       i_attached_source,
  input wire logic       i_flag_input_pin,
  input wire logic       i_flag_cuts_gate_bit,
  input wire logic       o_core_reset_n,
  input wire logic       o_in_init,
  input wire logic       o_func_enable,
  input wire logic       o_fault_output2_pin_o,
  input wire logic       o_fault_output2_pin_oe,
  input wire logic       o_charger_strap_output1_pin_o,
  input wire logic       o_charger_strap_output1_pin_oe,
  input wire logic       o_mode_strap_orientation_pin_o,
  input wire logic       o_mode_strap_orientation_pin_oe,
  input wire logic       o_debug_pin_o,
  input wire logic       o_debug_pin_oe,
  input wire logic       o_int_pin_o,
  input wire logic       o_gate_enable
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  logic [15:0] init_cnt_r;  // cycles in init
  // init counter
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) init_cnt_r <= 16'h0000;
    else init_cnt_r <= o_in_init ? init_cnt_r + 16'h0001 : 16'h0000;
  end
  // general output held steady
  sequence gpo_steady;
    i_output2_function_select == `SEL_GPO && $stable(i_output2_level_bit)
      && $stable(i_output_polarity_bit) && o_fault_output2_pin_oe;
  endsequence
  a_init_bounded: assert property (init_cnt_r <= INIT_CYCLES + 1)
    else $error("init lasted too long");
  a_unpowered_reset: assert property ((!i_aux_above_fall && !i_bus_above_fall) [*6]
    |-> !o_core_reset_n) else $error("core not held in reset");
  a_disable_stops: assert property (i_system_disable_n [*5] |-> !o_func_enable)
    else $error("functions run while disabled");
  a_init_pins_hiz: assert property (o_in_init |-> !(o_fault_output2_pin_oe
    || o_charger_strap_output1_pin_oe || o_mode_strap_orientation_pin_oe || o_debug_pin_oe))
    else $error("pin driven during init");
  a_orientation_output_code: assert property (o_mode_strap_orientation_pin_oe |->
    o_mode_strap_orientation_pin_o == ($past(i_status_orientation_output) == `ORIENTATION_OUTPUT_HIGH_CODE))
    else $error("orientation level wrong");
  a_debug_level: assert property (o_debug_pin_oe |-> o_debug_pin_o != $past(i_debug_accessory))
    else $error("debug level wrong");
  a_out1_level: assert property (o_charger_strap_output1_pin_oe
    |-> o_charger_strap_output1_pin_o == $past(i_output1_level_bit))
    else $error("output1 level wrong");
  a_gpo_level: assert property (gpo_steady [*3]
    |-> o_fault_output2_pin_o == (i_output2_level_bit ^ i_output_polarity_bit))
    else $error("general output level wrong");
  a_id_hiz: assert property ((i_output2_function_select == `SEL_ID && !i_attached_source) [*3]
    |-> !o_fault_output2_pin_oe) else $error("id pin driven as sink");
  a_flag_gate_cut: assert property ((i_flag_input_pin && i_flag_cuts_gate_bit) [*5]
    |-> !o_gate_enable) else $error("gate not cut by flag");
  a_int_open_drain: assert property (o_int_pin_o == 1'h0)
    else $error("interrupt drives high");
endmodule
bind pd_sink_strap_and_status_pins pd_pins_checker #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.*);

// >>> verif/bus_adc_model.sv
// link-domain converter that feeds bus voltage samples
`timescale 1ns/1ps
module bus_adc_model (
  input  wire logic        i_link_clk,
  input  wire logic        i_reset_n,
  input  wire logic [11:0] i_level,
  output logic             o_adc_valid,
  output logic [11:0]      o_adc_data
);
  logic [3:0] tick_r;  // sample spacing
  // data scrambles late in each spacing
  always_ff @(posedge i_link_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_r      <= 4'h0;
      o_adc_valid <= 1'h0;
      o_adc_data  <= 12'h000;
    end else begin
      tick_r      <= tick_r + 4'h1;
      o_adc_valid <= (tick_r == 4'hF);
      o_adc_data  <= (tick_r == 4'hF) ? i_level : (tick_r[3] ? ~o_adc_data : o_adc_data);
    end
  end
endmodule

// >>> verif/testbench.sv
// self-checking bench for the strap and status pin block
`timescale 1ns/1ps
`include "pd_strap_map.svh"
module testbench;
  import pd_strap_pkg::*;
  logic i_core_clk = 0, i_link_clk = 0, i_reset_n = 0;
  logic i_aux_above_rise, i_aux_above_fall, i_bus_above_rise, i_bus_above_fall;
  logic i_system_disable_n, i_ctrl_enable, i_mode_strap_high, i_mode_strap_low;
  logic i_charger_strap_low, i_debug_strap, i_extended_range_capability_bit, i_adc_valid;
  ohm_type i_voltage_setting_pin, i_current_setting_pin;
  volt_type i_fused_profile_voltage, o_requested_voltage;
  amp_type i_fused_profile_current, o_requested_current, o_decoded_current_setting;
  logic [11:0] i_adc_data, o_bus_voltage_reading, adc_level;
  logic [1:0] i_output2_function_select, i_status_orientation_output;
  logic i_output_polarity_bit, i_output2_level_bit, i_output1_level_bit, i_no_profile_match;
  logic i_fault_state, i_software_reset_command, i_hard_reset, i_attached_source;
  logic i_debug_accessory, i_flag_input_pin, i_flag_mask, i_flag_cuts_gate_bit, i_gate_request;
  logic o_core_reset_n, o_in_init, o_func_enable, o_i2c_mode, o_i2c_pins_analog, o_gate_enable;
  logic [7:0] o_i2c_address;
  logic o_high_voltage_dedicated_charger, o_fault_output2_pin_o, o_fault_output2_pin_oe;
  logic o_charger_strap_output1_pin_o, o_charger_strap_output1_pin_oe;
  logic o_mode_strap_orientation_pin_o, o_mode_strap_orientation_pin_oe;
  logic o_debug_pin_o, o_debug_pin_oe, o_int_pin_o, o_int_pin_oe;
  int fail_count = 0, comparisons = 0, seed = 44518, m, kind, rv, ri, ev, ei;
  pd_sink_strap_and_status_pins #(.INIT_CYCLES(20)) dut (.*);
  bus_adc_model adc (.i_link_clk, .i_reset_n, .i_level(adc_level),
    .o_adc_valid(i_adc_valid), .o_adc_data(i_adc_data));
  initial forever #50 i_core_clk = ~i_core_clk;
  initial begin
    #7;
    forever #24 i_link_clk = ~i_link_clk;
  end
  task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // bounded wait on a level
  task automatic wait_lvl(ref logic s, input logic v);
    for (int k = 0; k < 200 && s !== v; k++) @(negedge i_core_clk);
    if (s !== v) begin
      chk("wait", s, v);
      finish_test;
    end
  endtask
  // power cycle through one supply
  task automatic power(bit via_aux);
    {i_aux_above_rise, i_aux_above_fall, i_bus_above_rise, i_bus_above_fall} = 4'h0;
    cyc(8);
    chk("core_reset_n", o_core_reset_n, 0);
    {i_aux_above_rise, i_aux_above_fall} = {2{via_aux}};
    {i_bus_above_rise, i_bus_above_fall} = {2{!via_aux}};
    wait_lvl(o_in_init, 1);
    wait_lvl(o_in_init, 0);
    cyc(4);
  endtask
  function automatic int vdec(int r, bit ext);
    int b[5] = '{15, 45, 85, 151, 300};
    int vv[6] = '{5, 9, 12, 15, 20, 28};
    int k = 0;
    foreach (b[i]) if (r >= b[i]) k++;
    return (k == 5 && !ext) ? 20 : vv[k];
  endfunction
  function automatic int idec(int r);
    int b[8] = '{11, 31, 50, 72, 100, 137, 184, 300};
    int k = 5;
    foreach (b[i]) if (r >= b[i]) k++;
    return k;
  endfunction
  initial begin
    int vn[6] = '{0, 30, 60, 110, 191, 511};
    int in_[9] = '{0, 23, 40, 60, 85, 115, 158, 210, 511};
    {i_aux_above_rise, i_aux_above_fall, i_bus_above_rise, i_bus_above_fall, i_system_disable_n,
     i_mode_strap_high, i_mode_strap_low, i_charger_strap_low, i_debug_strap, i_output2_level_bit,
     i_extended_range_capability_bit, i_output2_function_select, i_status_orientation_output, i_hard_reset,
     i_output_polarity_bit, i_output1_level_bit, i_no_profile_match, i_fault_state, i_flag_mask,
     i_software_reset_command, i_attached_source, i_debug_accessory, i_flag_input_pin,
     i_flag_cuts_gate_bit, i_gate_request, i_voltage_setting_pin, i_current_setting_pin} = '0;
    {i_ctrl_enable, i_fused_profile_voltage, i_fused_profile_current, adc_level} = '1;
    repeat (20) @(negedge i_core_clk);
    i_reset_n = 1;
    // every strap setting, ending in pin mode
    for (m = 0; m < 6; m++) begin
      kind = (m + 2) % 3;
      i_mode_strap_high = kind == 0;
      i_mode_strap_low = kind == 2;
      i_charger_strap_low = m / 3;
      power(m[0]);
      {i_mode_strap_high, i_charger_strap_low} = ~{i_mode_strap_high, i_charger_strap_low};
      cyc(5);
      chk("i2c_mode", o_i2c_mode, kind != 1);
      if (kind != 1) chk("address", o_i2c_address, kind == 0 ? `ADDR_HIGH : `ADDR_LOW);
      chk("pins_analog", o_i2c_pins_analog, kind == 1);
      chk("high_voltage_dedicated_charger", o_high_voltage_dedicated_charger, m < 3);
      chk("orientation_output_oe", o_mode_strap_orientation_pin_oe, 1);
      i_ctrl_enable = 0;
      cyc(5);
      chk("ctrl_gate", o_func_enable, kind == 1);
      i_ctrl_enable = 1;
      i_system_disable_n = 1;
      cyc(6);
      chk("disabled", o_func_enable, 0);
      i_system_disable_n = 0;
      cyc(6);
      chk("enabled", o_func_enable, 1);
    end
    // resistor codes, fuses, converter
    for (m = 0; m < 40; m++) begin
      rv = vn[$unsigned($random(seed)) % 6];
      ri = in_[$unsigned($random(seed)) % 9];
      if (rv < 300) rv = rv + rv / 100 * ($random(seed) % 2);
      if (ri < 300) ri = ri + ri / 100 * ($random(seed) % 2);
      i_voltage_setting_pin = 9'(rv);
      i_current_setting_pin = 9'(ri);
      i_extended_range_capability_bit = $random(seed);
      i_fused_profile_voltage = ($random(seed) & 1) ? `V28 : `V12;
      i_fused_profile_current = 4'(($random(seed) & 7) + 6);
      adc_level = $random(seed);
      cyc(30);
      ev = vdec(rv, i_extended_range_capability_bit);
      ei = idec(ri);
      chk("voltage", o_requested_voltage, ev < i_fused_profile_voltage ? ev : i_fused_profile_voltage);
      chk("dec_current", o_decoded_current_setting, ei);
      chk("current", o_requested_current, ei < i_fused_profile_current ? ei : i_fused_profile_current);
      chk("bus_reading", o_bus_voltage_reading, adc_level);
    end
    // status pins
    for (m = 0; m < 30; m++) begin
      {i_status_orientation_output, i_debug_accessory, i_output1_level_bit, i_output2_level_bit,
       i_output_polarity_bit, i_attached_source} = 7'($random(seed));
      i_output2_function_select = m[0] ? `SEL_GPO : `SEL_ID;
      cyc(4);
      chk("orientation_output", o_mode_strap_orientation_pin_o, i_status_orientation_output == `ORIENTATION_OUTPUT_HIGH_CODE);
      chk("debug", o_debug_pin_o, !i_debug_accessory);
      chk("out1", o_charger_strap_output1_pin_o, i_output1_level_bit);
      if (m[0]) chk("gpo", o_fault_output2_pin_o, i_output2_level_bit ^ i_output_polarity_bit);
      else chk("id_oe", o_fault_output2_pin_oe, i_attached_source);
    end
    // fault causes and clears
    i_output2_function_select = `SEL_FAULT;
    i_output_polarity_bit = 0;
    cyc(4);
    chk("fault_idle", o_fault_output2_pin_o, 0);
    for (m = 0; m < 3; m++) begin
      i_no_profile_match = m != 1;
      i_fault_state = m == 1;
      cyc(4);
      chk("fault_set", o_fault_output2_pin_o, 1);
      {i_no_profile_match, i_fault_state} = 2'h0;
      cyc(3);
      chk("fault_held", o_fault_output2_pin_o, 1);
      case (m)
        0: i_software_reset_command = 1;
        1: i_hard_reset = 1;
        default: i_output2_function_select = 2'h3;
      endcase
      cyc(1);
      {i_software_reset_command, i_hard_reset} = 2'h0;
      i_output2_function_select = `SEL_FAULT;
      cyc(4);
      chk("fault_clear", o_fault_output2_pin_o, 0);
    end
    // flag input
    i_gate_request = 1;
    for (m = 0; m < 4; m++) begin
      {i_flag_mask, i_flag_cuts_gate_bit} = 2'(3 - m);
      i_flag_input_pin = 1;
      cyc(6);
      chk("int_oe", o_int_pin_oe, !i_flag_mask);
      chk("gate", o_gate_enable, !i_flag_cuts_gate_bit);
      i_flag_input_pin = 0;
      cyc(6);
      chk("gate_back", o_gate_enable, 1);
    end
    finish_test;
  end
endmodule
